// ---- verilog/mpc_pkg.sv ----
package mpc_pkg;
	// register offsets on the plain port (byte addresses)
	localparam logic [7:0] OFS_TYPE       = 8'h00;
	localparam logic [7:0] OFS_CTRL       = 8'h04;
	localparam logic [7:0] OFS_RSEL       = 8'h08;
	localparam logic [7:0] OFS_RBASE      = 8'h0c;
	localparam logic [7:0] OFS_RATTR      = 8'h10;
	// control fields
	localparam int CTRL_ENABLE_BIT        = 0;
	localparam int CTRL_HANDLER_BIT       = 1;
	localparam int CTRL_BACKGROUND_BIT    = 2;
	// type fields
	localparam int TYPE_DCOUNT_LSB        = 8;
	localparam int TYPE_ICOUNT_LSB        = 16;
	localparam int TYPE_SPLIT_BIT         = 0;
	// base address register fields
	localparam int RBASE_VALID_BIT        = 4;
	localparam int RBASE_REGION_LSB       = 0;
	localparam int RBASE_REGION_W         = 4;
	// attribute register fields
	localparam int RATTR_ENABLE_BIT       = 0;
	localparam int RATTR_SIZE_LSB         = 1;
	localparam int RATTR_XN_BIT           = 28;
	// reset values
	localparam logic [2:0]  CTRL_RESET    = 3'h0;
	localparam logic [7:0]  RSEL_RESET    = 8'h00;
	localparam logic [7:0]  ICOUNT_VALUE  = 8'h00;
	// fixed system windows
	localparam logic [31:0] SCS_BASE      = 32'he000e000;
	localparam logic [31:0] SCS_LIMIT     = 32'he000efff;
	localparam logic [31:0] VTAB_BASE     = 32'h00000000;
	localparam logic [31:0] VTAB_LIMIT    = 32'h000003ff;
endpackage : mpc_pkg

// ---- verilog/mpc_region_match.sv ----
`timescale 1ns/1ps
// one region: enabled, sized window compare, returns hit and execute-never
module mpc_region_match
	import mpc_pkg::*;
(
	input  wire logic [31:0] base,
	input  wire logic [31:0] attr,
	input  wire logic [31:0] addr,
	output logic             hit,
	output logic             xn
);
	logic [4:0]  size_f;
	logic [31:0] mask;
	assign size_f = attr[RATTR_SIZE_LSB +: 5];
	// region size is 2^(size+1) bytes; size 31 covers the whole map
	assign mask = (size_f == 5'h1f) ? 32'h00000000 : ~((32'h00000002 << size_f) - 32'h00000001);
	assign hit  = attr[RATTR_ENABLE_BIT] && (size_f >= 5'h04) && ((addr & mask) == (base & mask));
	assign xn   = attr[RATTR_XN_BIT];
endmodule : mpc_region_match

// ---- verilog/mpc_protection_control.sv ----
`timescale 1ns/1ps
module mpc_protection_control
	import mpc_pkg::*;
#(
	parameter bit IMPLEMENTED  = 1'b1,
	parameter int REGION_COUNT = 16
)(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic        acc_valid,
	input  wire logic [31:0] acc_addr,
	input  wire logic        acc_priv,
	input  wire logic        acc_fetch,
	input  wire logic        acc_high_pri,
	output logic             acc_done,
	output logic             acc_permit,
	output logic             acc_fault,
	output logic             acc_default_map,
	output logic             acc_exec_never,
	output logic             acc_strong_order
);
	localparam int RW = $clog2(REGION_COUNT);

	logic [2:0]  ctrl;
	logic [7:0]  region_sel;
	logic [31:0] base_mem [REGION_COUNT];
	logic [31:0] attr_mem [REGION_COUNT];
	logic [REGION_COUNT-1:0] hit_v;
	logic [REGION_COUNT-1:0] xn_v;
	logic [RW-1:0] sel_idx;
	logic        next_hit;
	logic        next_xn;
	logic        in_scs;
	logic        in_vtab;
	logic        checking;
	logic        next_permit;
	logic        next_default;
	logic        next_xn_out;
	logic [31:0] next_rdata;
	logic        unit_on;
	logic        handler_on;
	logic        background_on;
	logic        sys_window;
	logic        bg_serves;
	logic        wr_ctrl;
	logic        wr_rsel;
	logic        wr_rbase;
	logic        wr_rattr;
	logic        base_loads_sel;
	logic [RW-1:0] base_idx;
	logic [31:0] type_word;
	logic [31:0] rbase_word;

	function automatic logic in_window(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		in_window = (a >= lo) && (a <= hi);
	endfunction : in_window

	// one decode for every register write strobe, so an absent unit drops all writes in one place
	function automatic logic reg_hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
		reg_hit = IMPLEMENTED && strobe && (a == ofs);
	endfunction : reg_hit

	// region numbers keep only the bits the tables can index
	function automatic logic [RW-1:0] region_field(input logic [31:0] w);
		region_field = w[RW-1:0];
	endfunction : region_field

	assign sel_idx = region_sel[RW-1:0];
	assign wr_ctrl        = reg_hit(reg_wr, reg_addr, OFS_CTRL);
	assign wr_rsel        = reg_hit(reg_wr, reg_addr, OFS_RSEL);
	assign wr_rbase       = reg_hit(reg_wr, reg_addr, OFS_RBASE);
	assign wr_rattr       = reg_hit(reg_wr, reg_addr, OFS_RATTR);
	assign base_loads_sel = wr_rbase && reg_wdata[RBASE_VALID_BIT];
	// a valid base write names its own region, otherwise the selected one is written
	assign base_idx       = base_loads_sel ? region_field(reg_wdata) : sel_idx;

	// named control bits; the handler bit only matters while the unit is on
	assign unit_on       = IMPLEMENTED && ctrl[CTRL_ENABLE_BIT];
	assign handler_on    = ctrl[CTRL_HANDLER_BIT];
	assign background_on = ctrl[CTRL_BACKGROUND_BIT];

	// control register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata[2:0];
		end
	end

	// region select, also loaded by a valid base-address write
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			region_sel <= RSEL_RESET;
		end else if (wr_rsel) begin
			region_sel <= 8'(region_field(reg_wdata));
		end else if (base_loads_sel) begin
			region_sel <= 8'(region_field(reg_wdata));
		end
	end

	// base table; the low five bits are not stored since the smallest region is 32 bytes
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < REGION_COUNT; i++) begin
				base_mem[i] <= 32'h00000000;
			end
		end else if (wr_rbase) begin
			base_mem[base_idx] <= {reg_wdata[31:5], 5'h00};
		end
	end

	// attribute table, always the selected region
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < REGION_COUNT; i++) begin
				attr_mem[i] <= 32'h00000000;
			end
		end else if (wr_rattr) begin
			attr_mem[sel_idx] <= reg_wdata;
		end
	end

	// identification word is fixed by the parameters; everything outside the count fields stays zero
	always_comb begin
		type_word                       = 32'h00000000;
		type_word[TYPE_ICOUNT_LSB +: 8] = ICOUNT_VALUE;
		type_word[TYPE_DCOUNT_LSB +: 8] = 8'(REGION_COUNT);
		type_word[TYPE_SPLIT_BIT]       = 1'b0;
	end

	// the valid bit always reads zero; the region field shows the current selection
	assign rbase_word = {base_mem[sel_idx][31:5], 1'b0, 4'(sel_idx)};

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h00000000;
		if (IMPLEMENTED) begin
			unique case (reg_addr)
				OFS_TYPE:  next_rdata = type_word;
				OFS_CTRL:  next_rdata[2:0] = ctrl;
				OFS_RSEL:  next_rdata[7:0] = region_sel;
				OFS_RBASE: next_rdata = rbase_word;
				OFS_RATTR: next_rdata = attr_mem[sel_idx];
				default:   next_rdata = 32'h00000000;
			endcase
		end
	end

	// read data holds until the next read, so a slow reader still sees it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// region compare
	genvar g;
	generate
		for (g = 0; g < REGION_COUNT; g++) begin : gen_region
			mpc_region_match u_match (
				.base (base_mem[g]),
				.attr (attr_mem[g]),
				.addr (acc_addr),
				.hit  (hit_v[g]),
				.xn   (xn_v[g])
			);
		end
	endgenerate

	// highest numbered hit wins, scan upward so later overrides
	always_comb begin
		next_hit = 1'b0;
		next_xn  = 1'b0;
		for (int i = 0; i < REGION_COUNT; i++) begin
			if (hit_v[i]) begin
				next_hit = 1'b1;
				next_xn  = xn_v[i];
			end
		end
	end

	assign in_scs  = in_window(acc_addr, SCS_BASE, SCS_LIMIT);
	assign in_vtab = in_window(acc_addr, VTAB_BASE, VTAB_LIMIT);
	// windows that software must always reach while the unit is on
	assign sys_window = in_scs || in_vtab;
	// handler bypass: checking off at priority -1/-2 unless allowed
	assign checking = unit_on
		&& (!acc_high_pri || handler_on);
	// the background only ever serves privileged code
	assign bg_serves = background_on && acc_priv;

	// permit decision in priority order; anything left over faults
	always_comb begin
		next_permit = 1'b0;
		if (!checking) begin
			next_permit = 1'b1;
		end else if (sys_window) begin
			next_permit = 1'b1;
		end else if (next_hit) begin
			next_permit = !(acc_fetch && next_xn);
		end else if (bg_serves) begin
			next_permit = 1'b1;
		end
		// fetches from the control space fault even with the unit off
		if (in_scs && acc_fetch) begin
			next_permit = 1'b0;
		end
	end

	// default-map attributes apply with checking off, in the system windows, or when the background serves a miss
	always_comb begin
		next_default = 1'b0;
		if (!checking || sys_window) begin
			next_default = 1'b1;
		end else if (!next_hit && bg_serves) begin
			next_default = 1'b1;
		end
	end

	// execute-never comes from the winning region, and always for the control space
	always_comb begin
		next_xn_out = 1'b0;
		if (in_scs) begin
			next_xn_out = 1'b1;
		end else if (checking && !in_vtab && next_hit) begin
			next_xn_out = next_xn;
		end
	end

	// every answer is a one-cycle pulse; without a request each output falls back to zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc_done <= 1'b0;
		end else begin
			acc_done <= acc_valid;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc_permit <= 1'b0;
		end else begin
			acc_permit <= acc_valid && next_permit;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc_fault <= 1'b0;
		end else begin
			acc_fault <= acc_valid && !next_permit;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc_default_map <= 1'b0;
		end else begin
			acc_default_map <= acc_valid && next_default;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc_exec_never <= 1'b0;
		end else begin
			acc_exec_never <= acc_valid && next_xn_out;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc_strong_order <= 1'b0;
		end else begin
			acc_strong_order <= acc_valid && in_scs;
		end
	end
endmodule : mpc_protection_control

// ---- sim/mpc_protection_control_props.sv ----
`timescale 1ns/1ps
module mpc_props
	import mpc_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        acc_valid,
	input wire logic [31:0] acc_addr,
	input wire logic        acc_fetch,
	input wire logic        acc_done,
	input wire logic        acc_permit,
	input wire logic        acc_fault,
	input wire logic        acc_exec_never,
	input wire logic        acc_strong_order
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire scs = acc_addr[31:12] == 20'he000e;
	wire vtab = acc_addr < 32'h00000400;
	done_one_a: assert property (acc_valid |=> acc_done) else $error("no answer");
	done_idle_a: assert property (!acc_valid |=> !acc_done && !acc_permit && !acc_fault) else $error("stray answer");
	verdict_one_a: assert property (acc_done |-> acc_permit != acc_fault) else $error("bad verdict");
	scs_permit_a: assert property (acc_valid && scs && !acc_fetch |=> acc_permit) else $error("scs refused");
	scs_attr_a: assert property (acc_valid && scs |=> acc_exec_never && acc_strong_order) else $error("scs attr");
	vtab_permit_a: assert property (acc_valid && vtab && !acc_fetch |=> acc_permit) else $error("vtab refused");
	type_fields_a: assert property (reg_rd && reg_addr == OFS_TYPE |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[7:0] == 8'h00) else $error("type fields");
	rsel_spare_a: assert property (reg_rd && reg_addr == OFS_RSEL |=> reg_rdata[31:4] == 28'h0000000) else $error("rsel spare");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule : mpc_props

// ---- sim/mpc_core_model.sv ----
`timescale 1ns/1ps
module mpc_core_model (
	input  wire logic   clk_sys,
	output logic        acc_valid,
	output logic [31:0] acc_addr,
	output logic        acc_priv,
	output logic        acc_fetch,
	output logic        acc_high_pri,
	input  wire logic   acc_done,
	input  wire logic   acc_permit,
	input  wire logic   acc_fault
);
	initial begin
		{acc_valid, acc_priv, acc_fetch, acc_high_pri} = 4'h0;
		acc_addr = 32'h00000000;
	end
	// address is scrambled once taken so a stale value can never pass
	task automatic go(input logic [31:0] a, input logic [2:0] pfh, output logic [2:0] res);
		@(posedge clk_sys);
		acc_valid <= 1'b1;
		acc_addr <= a;
		{acc_priv, acc_fetch, acc_high_pri} <= pfh;
		@(posedge clk_sys);
		acc_valid <= 1'b0;
		acc_addr <= ~a;
		#1;
		res = {acc_done, acc_permit, acc_fault};
	endtask : go
endmodule : mpc_core_model

// ---- sim/test_memory_protection_control.sv ----
`timescale 1ns/1ps
module test_memory_protection_control
	import mpc_pkg::*;
;
	logic clk_sys, rst_b, reg_wr, reg_rd, acc_valid, acc_priv, acc_fetch, acc_high_pri;
	logic acc_done, acc_permit, acc_fault, acc_default_map, acc_exec_never, acc_strong_order;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, acc_addr;
	int errors = 0;
	int tests_run = 0;
	mpc_protection_control mpc_protection_control_inst (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .acc_valid, .acc_addr, .acc_priv, .acc_fetch, .acc_high_pri, .acc_done, .acc_permit,
		.acc_fault, .acc_default_map, .acc_exec_never, .acc_strong_order);
	mpc_core_model mpc_core_model_inst (.clk_sys, .acc_valid, .acc_addr, .acc_priv, .acc_fetch, .acc_high_pri,
		.acc_done, .acc_permit, .acc_fault);
	task automatic print_verdict;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask : rd
	// expected answer: done, then permit xor fault
	task automatic ac(input logic [31:0] a, input logic [2:0] pfh, input logic p, input logic d);
		logic [2:0] r;
		mpc_core_model_inst.go(a, pfh, r);
		chk($sformatf("access %h", a), {29'h00000001, p, ~p}, {29'h00000000, r});
		chk($sformatf("default map %h", a), {31'h00000000, d}, {31'h00000000, acc_default_map});
	endtask : ac
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#40000;
		errors++;
		print_verdict;
	end
	initial begin
		{rst_b, reg_wr, reg_rd} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(OFS_TYPE, 32'h00001000);
		wr(OFS_TYPE, 32'hffffffff);
		rd(OFS_TYPE, 32'h00001000);
		rd(OFS_CTRL, 32'h00000000);
		rd(8'h40, 32'h00000000);
		wr(OFS_RSEL, 32'hffffffff);
		rd(OFS_RSEL, 32'h0000000f);
		wr(OFS_RBASE, 32'h20000013);
		rd(OFS_RSEL, 32'h00000003);
		wr(OFS_RBASE, 32'h20000005);
		rd(OFS_RSEL, 32'h00000003);
		rd(OFS_RBASE, 32'h20000003);
		wr(OFS_RATTR, 32'h0000001f);
		rd(OFS_RATTR, 32'h0000001f);
		wr(OFS_CTRL, 32'h00000004);
		ac(32'h30000000, 3'b000, 1'b1, 1'b1);
		wr(OFS_CTRL, 32'hffffffff);
		rd(OFS_CTRL, 32'h00000007);
		wr(OFS_CTRL, 32'h00000001);
		ac(32'h30000000, 3'b100, 1'b0, 1'b0);
		ac(32'h30000000, 3'b101, 1'b1, 1'b1);
		ac(32'h20000100, 3'b010, 1'b1, 1'b0);
		ac(32'he000ed00, 3'b000, 1'b1, 1'b1);
		ac(32'h00000100, 3'b000, 1'b1, 1'b1);
		wr(OFS_CTRL, 32'h00000003);
		ac(32'h30000000, 3'b101, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h00000005);
		ac(32'h30000000, 3'b100, 1'b1, 1'b1);
		ac(32'h30000000, 3'b000, 1'b0, 1'b0);
		wr(OFS_RBASE, 32'h20000015);
		wr(OFS_RATTR, 32'h1000001f);
		ac(32'h20000100, 3'b010, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h00000000);
		ac(32'he000e100, 3'b010, 1'b0, 1'b1);
		print_verdict;
	end
endmodule : test_memory_protection_control
bind mpc_protection_control mpc_props mpc_props_inst (.clk_sys, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .acc_valid,
	.acc_addr, .acc_fetch, .acc_done, .acc_permit, .acc_fault, .acc_exec_never, .acc_strong_order);
